// ### verilog/cmia_irq_aggregator.v
// clock monitor interrupt aggregator with its register port
`timescale 1ns/1ps
`include "cmia_map.vh"
// How it works
// - status bit 15 is OR of enabled sources
// - interrupt only when global enable and status
// - pin carries interrupt when selector picks it
// - enables 8..4 gate activity and loss statuses
// - enables 3..0 gate loop event statuses
// - status 8..4 mirror monitor event flags
// - status 3..0 mirror loop event flags
// - loss flag sticks while loss persists
module cmia_irq_aggregator (
  mclk,
  nrst,
  regAddr,
  regWrite,
  regWdata,
  regRdata,
  secondaryActivityEvent,
  primaryActivityEvent,
  crystalLossCondition,
  secondaryLossCondition,
  primaryLossCondition,
  digitalLoopStateEvent,
  digitalLoopHoldoverEvent,
  digitalLoopLockLossEvent,
  analogLoopLockLossEvent,
  lockPinSelect,
  lockFunction,
  deviceIrq,
  lockStatusPin
);
  input  wire        mclk;
  input  wire        nrst;
  input  wire [7:0]  regAddr;
  input  wire        regWrite;
  input  wire [15:0] regWdata;
  output reg  [15:0] regRdata;
  input  wire        secondaryActivityEvent;
  input  wire        primaryActivityEvent;
  input  wire        crystalLossCondition;
  input  wire        secondaryLossCondition;
  input  wire        primaryLossCondition;
  input  wire        digitalLoopStateEvent;
  input  wire        digitalLoopHoldoverEvent;
  input  wire        digitalLoopLockLossEvent;
  input  wire        analogLoopLockLossEvent;
  input  wire [1:0]  lockPinSelect;
  input  wire        lockFunction;
  output wire        deviceIrq;
  output wire        lockStatusPin;

  // ----------------------------------------
  // internal state
  // ----------------------------------------
  reg  [15:0] irqEnable_reg;
  reg  [15:0] irqEnable_next;
  reg  [2:0]  losCtrl_reg;
  reg  [2:0]  losCtrl_next;
  reg  [15:0] regRdata_next;
  wire [2:0]  losEvent;
  wire [2:0]  losClear;
  wire [15:0] irqStatus;
  wire [8:0]  rawStatus;
  wire [8:0]  maskedStatus;
  wire        devStatus;
  wire        selEnable;
  wire        selStatus;
  wire        selLosEvt0;
  wire        selLosEvt1;
  wire        selLosEvt2;
  wire        selLosCtrl;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  assign selEnable  = (regAddr == `CMIA_OFF_INT_EN);
  assign selStatus  = (regAddr == `CMIA_OFF_INT_STS);
  assign selLosEvt0 = (regAddr == `CMIA_OFF_LOS_EVT0);
  assign selLosEvt1 = (regAddr == `CMIA_OFF_LOS_EVT1);
  assign selLosEvt2 = (regAddr == `CMIA_OFF_LOS_EVT2);
  assign selLosCtrl = (regAddr == `CMIA_OFF_LOS_CTRL);

  // ----------------------------------------
  // loss-of-signal event flags
  // ----------------------------------------
  // write one to bit 0 clears; live loss wins
  assign losClear[0] = regWrite & selLosEvt0 & regWdata[0];
  assign losClear[1] = regWrite & selLosEvt1 & regWdata[0];
  assign losClear[2] = regWrite & selLosEvt2 & regWdata[0];

  cmia_los_event uPrimaryLoss (
    .mclk          (mclk),
    .nrst          (nrst),
    .softReset     (losCtrl_reg[0]),
    .lossCondition (primaryLossCondition),
    .clearStrobe   (losClear[0]),
    .eventFlag     (losEvent[0])
  );
  cmia_los_event uSecondaryLoss (
    .mclk          (mclk),
    .nrst          (nrst),
    .softReset     (losCtrl_reg[1]),
    .lossCondition (secondaryLossCondition),
    .clearStrobe   (losClear[1]),
    .eventFlag     (losEvent[1])
  );
  cmia_los_event uCrystalLoss (
    .mclk          (mclk),
    .nrst          (nrst),
    .softReset     (losCtrl_reg[2]),
    .lossCondition (crystalLossCondition),
    .clearStrobe   (losClear[2]),
    .eventFlag     (losEvent[2])
  );

  // ----------------------------------------
  // status mirrors and aggregation
  // ----------------------------------------
  // mirrors are wires, so they follow the flags in the same cycle
  assign rawStatus[`CMIA_BIT_ACT1]   = secondaryActivityEvent;
  assign rawStatus[`CMIA_BIT_ACT0]   = primaryActivityEvent;
  assign rawStatus[`CMIA_BIT_LOS2]   = losEvent[2];
  assign rawStatus[`CMIA_BIT_LOS1]   = losEvent[1];
  assign rawStatus[`CMIA_BIT_LOS0]   = losEvent[0];
  assign rawStatus[`CMIA_BIT_DSTATE] = digitalLoopStateEvent;
  assign rawStatus[`CMIA_BIT_DHOLD]  = digitalLoopHoldoverEvent;
  assign rawStatus[`CMIA_BIT_DLOL]   = digitalLoopLockLossEvent;
  assign rawStatus[`CMIA_BIT_ALOL]   = analogLoopLockLossEvent;

  // ----------------------------------------
  // per-source masking
  // ----------------------------------------
  assign maskedStatus[`CMIA_BIT_ACT1] =
    rawStatus[`CMIA_BIT_ACT1] & irqEnable_reg[`CMIA_BIT_ACT1];
  assign maskedStatus[`CMIA_BIT_ACT0] =
    rawStatus[`CMIA_BIT_ACT0] & irqEnable_reg[`CMIA_BIT_ACT0];
  assign maskedStatus[`CMIA_BIT_LOS2] =
    rawStatus[`CMIA_BIT_LOS2] & irqEnable_reg[`CMIA_BIT_LOS2];
  assign maskedStatus[`CMIA_BIT_LOS1] =
    rawStatus[`CMIA_BIT_LOS1] & irqEnable_reg[`CMIA_BIT_LOS1];
  assign maskedStatus[`CMIA_BIT_LOS0] =
    rawStatus[`CMIA_BIT_LOS0] & irqEnable_reg[`CMIA_BIT_LOS0];
  assign maskedStatus[`CMIA_BIT_DSTATE] =
    rawStatus[`CMIA_BIT_DSTATE] & irqEnable_reg[`CMIA_BIT_DSTATE];
  assign maskedStatus[`CMIA_BIT_DHOLD] =
    rawStatus[`CMIA_BIT_DHOLD] & irqEnable_reg[`CMIA_BIT_DHOLD];
  assign maskedStatus[`CMIA_BIT_DLOL] =
    rawStatus[`CMIA_BIT_DLOL] & irqEnable_reg[`CMIA_BIT_DLOL];
  assign maskedStatus[`CMIA_BIT_ALOL] =
    rawStatus[`CMIA_BIT_ALOL] & irqEnable_reg[`CMIA_BIT_ALOL];

  // ----------------------------------------
  // device status and interrupt
  // ----------------------------------------
  assign devStatus = |maskedStatus;
  assign irqStatus = {devStatus, 6'h00, rawStatus};
  assign deviceIrq = irqEnable_reg[`CMIA_BIT_DEV] & devStatus;

  // ----------------------------------------
  // shared status pin
  // ----------------------------------------
  assign lockStatusPin = (lockPinSelect == `CMIA_SEL_DEV_IRQ) ?
                         deviceIrq : lockFunction;

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always @* begin
    irqEnable_next = irqEnable_reg;
    if (regWrite && selEnable) begin
      irqEnable_next = regWdata & `CMIA_EN_WMASK; // bits 14..12 stay zero
    end
  end

  always @* begin
    losCtrl_next = losCtrl_reg;
    if (regWrite && selLosCtrl) begin
      losCtrl_next = regWdata[2:0]; // soft resets driven by host
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irqEnable_reg <= `CMIA_RST_INT_EN;
      losCtrl_reg   <= `CMIA_RST_LOS_CTRL;
    end else begin
      irqEnable_reg <= irqEnable_next;
      losCtrl_reg   <= losCtrl_next;
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  always @* begin
    regRdata_next = 16'h0000; // unmapped indices read as zero
    if (selEnable) begin
      regRdata_next = irqEnable_reg;
    end else if (selStatus) begin
      regRdata_next = irqStatus;
    end else if (selLosEvt0) begin
      regRdata_next = {15'h0, losEvent[0]};
    end else if (selLosEvt1) begin
      regRdata_next = {15'h0, losEvent[1]};
    end else if (selLosEvt2) begin
      regRdata_next = {15'h0, losEvent[2]};
    end else if (selLosCtrl) begin
      regRdata_next = {13'h0, losCtrl_reg};
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      regRdata <= 16'h0000;
    end else begin
      regRdata <= regRdata_next;
    end
  end
endmodule // cmia_irq_aggregator

// ### verilog/cmia_map.vh
// register offsets, field positions and reset values of the interrupt aggregator
`ifndef CMIA_MAP_VH
`define CMIA_MAP_VH
`define CMIA_OFF_INT_EN      8'h00
`define CMIA_OFF_INT_STS     8'h01
`define CMIA_OFF_LOS_EVT0    8'h02
`define CMIA_OFF_LOS_EVT1    8'h03
`define CMIA_OFF_LOS_EVT2    8'h04
`define CMIA_OFF_LOS_CTRL    8'h05
`define CMIA_BIT_DEV         15
`define CMIA_BIT_ACT1        8
`define CMIA_BIT_ACT0        7
`define CMIA_BIT_LOS2        6
`define CMIA_BIT_LOS1        5
`define CMIA_BIT_LOS0        4
`define CMIA_BIT_DSTATE      3
`define CMIA_BIT_DHOLD       2
`define CMIA_BIT_DLOL        1
`define CMIA_BIT_ALOL        0
`define CMIA_RST_INT_EN      16'h0000
`define CMIA_RST_LOS_EVT     1'b1
`define CMIA_RST_LOS_CTRL    3'h0
`define CMIA_EN_WMASK        16'h8fff
`define CMIA_SEL_DEV_IRQ     2'h1
`endif

// ### verilog/cmia_los_event.v
// one loss-of-signal sticky event flag
`timescale 1ns/1ps
`include "cmia_map.vh"
module cmia_los_event (
  mclk,
  nrst,
  softReset,
  lossCondition,
  clearStrobe,
  eventFlag
);
  input  wire mclk;
  input  wire nrst;
  input  wire softReset;
  input  wire lossCondition;
  input  wire clearStrobe;
  output wire eventFlag;

  reg flag_reg;
  reg flag_next;
  reg softReset_reg;

  // ----------------------------------------
  // flag logic
  // ----------------------------------------
  always @* begin
    flag_next = flag_reg;
    if (softReset) begin
      flag_next = `CMIA_RST_LOS_EVT;
    end else if (softReset_reg) begin
      flag_next = `CMIA_RST_LOS_EVT; // set on leaving reset
    end else if (lossCondition) begin
      flag_next = 1'b1; // clear ignored while loss persists
    end else if (clearStrobe) begin
      flag_next = 1'b0;
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      flag_reg      <= `CMIA_RST_LOS_EVT;
      softReset_reg <= 1'b0;
    end else begin
      flag_reg      <= flag_next;
      softReset_reg <= softReset;
    end
  end

  assign eventFlag = flag_reg;
endmodule // cmia_los_event

// ### dv/cmia_irq_aggregator_assertions.sv
// checker for the interrupt aggregator ports
`timescale 1ns/1ps
module cmia_irq_aggregator_assertions (
  input wire        mclk,
  input wire        nrst,
  input wire        regWrite,
  input wire        lockFunction,
  input wire        deviceIrq,
  input wire        lockStatusPin,
  input wire [7:0]  regAddr,
  input wire [15:0] regWdata,
  input wire [15:0] regRdata,
  input wire [1:0]  lockPinSelect,
  input wire        secondaryActivityEvent,
  input wire        primaryActivityEvent,
  input wire        crystalLossCondition,
  input wire        secondaryLossCondition,
  input wire        primaryLossCondition,
  input wire        digitalLoopStateEvent,
  input wire        digitalLoopHoldoverEvent,
  input wire        digitalLoopLockLossEvent,
  input wire        analogLoopLockLossEvent
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_pin; lockPinSelect == 2'h1 |-> lockStatusPin == deviceIrq; endproperty
  a_pin: assert property (p_pin) else $error("pin not irq");
  property p_pin_oth; lockPinSelect != 2'h1 |-> lockStatusPin == lockFunction; endproperty
  a_pin_oth: assert property (p_pin_oth) else $error("pin not other function");
  property p_irq_sts; $past(regAddr) == 8'h01 && $past(deviceIrq) |-> regRdata[15]; endproperty
  a_irq_sts: assert property (p_irq_sts) else $error("irq without status");
  property p_irq_en; $past(regAddr) == 8'h00 && $past(deviceIrq) |-> regRdata[15]; endproperty
  a_irq_en: assert property (p_irq_en) else $error("irq without global enable");
  property p_act; $past(regAddr) == 8'h01 |->
    regRdata[8:7] == {$past(secondaryActivityEvent), $past(primaryActivityEvent)}; endproperty
  a_act: assert property (p_act) else $error("activity mirror");
  property p_loop; $past(regAddr) == 8'h01 |-> regRdata[3:0] == {$past(digitalLoopStateEvent),
    $past(digitalLoopHoldoverEvent), $past(digitalLoopLockLossEvent),
    $past(analogLoopLockLossEvent)}; endproperty
  a_loop: assert property (p_loop) else $error("loop mirror");
  property p_en_wr; regWrite && regAddr == 8'h00 ##1 regAddr == 8'h00 && !regWrite |=>
    regRdata == ($past(regWdata, 2) & 16'h8fff); endproperty
  a_en_wr: assert property (p_en_wr) else $error("enable readback");
  property p_stick; $past(primaryLossCondition, 2) && $past(primaryLossCondition) &&
    $past(regAddr) == 8'h02 |-> regRdata[0]; endproperty
  a_stick: assert property (p_stick) else $error("loss flag dropped");
  property p_unmap; $past(regAddr) > 8'h05 |-> regRdata == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
endmodule // cmia_irq_aggregator_assertions

// ### dv/cmia_host_model.sv
// host model counting rises of the status pin
`timescale 1ns/1ps
module cmia_host_model (
  input wire       mclk,
  input wire       lockStatusPin,
  output reg [7:0] irqCount
);
  reg pinLast = 1'b0;
  initial irqCount = 8'h00;
  always @(posedge mclk) begin
    pinLast <= lockStatusPin;
    if (lockStatusPin && !pinLast) irqCount <= irqCount + 8'h01;
  end
endmodule // cmia_host_model

// ### dv/tb.sv
// self-checking bench for the interrupt aggregator
`timescale 1ns/1ps
module tb;
  reg mclk = 0, nrst = 0, regWrite = 0, lockFunction = 0;
  reg secondaryActivityEvent = 0, primaryActivityEvent = 0, crystalLossCondition = 0;
  reg secondaryLossCondition = 0, primaryLossCondition = 0, digitalLoopStateEvent = 0;
  reg digitalLoopHoldoverEvent = 0, digitalLoopLockLossEvent = 0, analogLoopLockLossEvent = 0;
  reg [7:0] regAddr = 8'h00;
  reg [15:0] regWdata = 16'h0000;
  reg [1:0] lockPinSelect = 2'h1;
  wire [15:0] regRdata;
  wire deviceIrq, lockStatusPin;
  wire [7:0] irqCount;
  integer n_mismatch = 0, cmp_count = 0, i;
  always #20 mclk = ~mclk;
  cmia_irq_aggregator u_dut (
    .mclk                     (mclk),
    .nrst                     (nrst),
    .regAddr                  (regAddr),
    .regWrite                 (regWrite),
    .regWdata                 (regWdata),
    .regRdata                 (regRdata),
    .secondaryActivityEvent   (secondaryActivityEvent),
    .primaryActivityEvent     (primaryActivityEvent),
    .crystalLossCondition     (crystalLossCondition),
    .secondaryLossCondition   (secondaryLossCondition),
    .primaryLossCondition     (primaryLossCondition),
    .digitalLoopStateEvent    (digitalLoopStateEvent),
    .digitalLoopHoldoverEvent (digitalLoopHoldoverEvent),
    .digitalLoopLockLossEvent (digitalLoopLockLossEvent),
    .analogLoopLockLossEvent  (analogLoopLockLossEvent),
    .lockPinSelect            (lockPinSelect),
    .lockFunction             (lockFunction),
    .deviceIrq                (deviceIrq),
    .lockStatusPin            (lockStatusPin)
  );
  cmia_host_model u_host (.mclk(mclk), .lockStatusPin(lockStatusPin), .irqCount(irqCount));
  task chk(input string nm, input [15:0] exp, input [15:0] got);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task src(input [8:0] v);
    @(posedge mclk) {secondaryActivityEvent, primaryActivityEvent, crystalLossCondition,
      secondaryLossCondition, primaryLossCondition, digitalLoopStateEvent,
      digitalLoopHoldoverEvent, digitalLoopLockLossEvent, analogLoopLockLossEvent} <= v;
    #1;
  endtask
  task wr(input [7:0] a, input [15:0] d);
    @(posedge mclk) {regAddr, regWrite, regWdata} <= {a, 1'b1, d};
    @(posedge mclk) regWrite <= 1'b0;
    #1;
  endtask
  task rd(input [7:0] a, input [15:0] exp, input string nm);
    @(posedge mclk) regAddr <= a;
    @(posedge mclk) #1 chk(nm, exp, regRdata);
  endtask
  task t_mask;
    rd(8'h00, 16'h0000, "enable");
    rd(8'h01, 16'h0070, "status");
    rd(8'h07, 16'h0000, "unmapped");
    wr(8'h00, 16'hffff);
    rd(8'h00, 16'h8fff, "enable");
    wr(8'h01, 16'h0000);
    rd(8'h01, 16'h8070, "status");
    chk("irq", 16'h1, deviceIrq);
    wr(8'h00, 16'h0fff);
    chk("irq", 16'h0, deviceIrq);
    @(posedge mclk) {lockPinSelect, lockFunction} <= {2'h2, 1'b1};
    #1 chk("pin", 16'h1, lockStatusPin);
    @(posedge mclk) lockPinSelect <= 2'h1;
    #1 chk("pin", 16'h0, lockStatusPin);
    $display("test mask done");
  endtask
  task t_loss;
    wr(8'h05, 16'h0007);
    wr(8'h02, 16'h0001);
    rd(8'h02, 16'h0001, "primary flag in soft reset");
    rd(8'h05, 16'h0007, "soft reset control");
    wr(8'h05, 16'h0000);
    repeat (2) @(posedge mclk);
    for (i = 2; i < 5; i = i + 1) wr(i[7:0], 16'h0001);
    rd(8'h03, 16'h0000, "secondary flag");
    rd(8'h01, 16'h0000, "status");
    src(9'h050);
    wr(8'h04, 16'h0001);
    rd(8'h04, 16'h0001, "crystal flag");
    rd(8'h02, 16'h0001, "primary flag");
    rd(8'h01, 16'h8050, "status");
    wr(8'h00, 16'h8040);
    chk("irq", 16'h1, lockStatusPin);
    src(9'h000);
    for (i = 2; i < 5; i = i + 1) wr(i[7:0], 16'h0001);
    chk("irq", 16'h0, deviceIrq);
    chk("host count", 16'h0003, {8'h00, irqCount});
    $display("test loss done");
  endtask
  task t_src;
    for (i = 0; i < 9; i = i + 1) if (i < 4 || i > 6) begin
      src(9'h001 << i);
      wr(8'h00, 16'h8000 | (16'h0001 << i));
      chk("irq", 16'h1, deviceIrq);
      rd(8'h01, 16'h8000 | (16'h0001 << i), "status");
      wr(8'h00, 16'h0001 << i);
      chk("irq", 16'h0, deviceIrq);
      wr(8'h00, 16'h8fff & ~(16'h0001 << i));
      chk("irq", 16'h0, deviceIrq);
    end
    $display("test sources done");
  endtask
  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    tally_and_finish;
  end
  initial begin
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    t_mask;
    t_loss;
    t_src;
    tally_and_finish;
  end
endmodule // tb
bind cmia_irq_aggregator cmia_irq_aggregator_assertions u_chk (
  .mclk                     (mclk),
  .nrst                     (nrst),
  .regWrite                 (regWrite),
  .lockFunction             (lockFunction),
  .deviceIrq                (deviceIrq),
  .lockStatusPin            (lockStatusPin),
  .regAddr                  (regAddr),
  .regWdata                 (regWdata),
  .regRdata                 (regRdata),
  .lockPinSelect            (lockPinSelect),
  .secondaryActivityEvent   (secondaryActivityEvent),
  .primaryActivityEvent     (primaryActivityEvent),
  .crystalLossCondition     (crystalLossCondition),
  .secondaryLossCondition   (secondaryLossCondition),
  .primaryLossCondition     (primaryLossCondition),
  .digitalLoopStateEvent    (digitalLoopStateEvent),
  .digitalLoopHoldoverEvent (digitalLoopHoldoverEvent),
  .digitalLoopLockLossEvent (digitalLoopLockLossEvent),
  .analogLoopLockLossEvent  (analogLoopLockLossEvent)
);
